// ===== verilog/ede_dma_engine.sv
// ethernet descriptor dma: transmit descriptor walk, receive fetch
// assumes memory answers each held request with a one-cycle mem_ack
//
// How it works
// - zero buffer one size skips that buffer
// - buffer two size ignored when chained
// - word 2 is buffer one address, any alignment
// - last segment timestamp low goes to word 2
// - last segment timestamp high goes to word 3
// - word 3 is buffer two or next descriptor
// - receive fetches one descriptor ahead after each close
// - fetch on poll demand and receive start
// - fetch on buffer full, suspend, unclosed frame
// - forward on threshold plus filter, or whole frame
// - new frame while suspended rereads current descriptor
// - host owned: drop head frame, count missed
// - flush disabled: keep frame, flag, suspend again
// - ownership bit 31, cleared when done
// - chain bit 20 selects next transmit descriptor address unless end of ring; receive steps 16 bytes
// - bit 29 marks last segment for timestamps
`timescale 1ns/1ps
`default_nettype none
module ede_dma_engine (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // register port
  input  wire logic [ede_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [31:0]                    reg_rdata,
  // host memory
  output logic                           mem_req,
  output logic                           mem_we,
  output logic [31:0]                    mem_addr,
  output logic [31:0]                    mem_wdata,
  input  wire logic                      mem_ack,
  input  wire logic [31:0]               mem_rdata,
  // mac transmit side
  output logic                           tx_buf_valid,
  output logic [31:0]                    tx_buf_addr,
  output logic [12:0]                    tx_buf_len,
  input  wire logic                      tx_buf_ready,
  input  wire logic                      tx_ts_valid,
  input  wire logic [63:0]               tx_ts,
  // mac receive side
  input  wire logic                      rx_new_frame,
  input  wire logic [ede_pkg::THR_W-1:0] rx_head_bytes,
  input  wire logic                      rx_head_complete,
  input  wire logic                      rx_head_addr_pass,
  input  wire logic [7:0]                rx_fifo_frames,
  input  wire logic                      rx_buf_full,
  input  wire logic                      rx_frame_end,
  input  wire logic                      rx_desc_closed,
  output logic                           rx_xfer_en,
  output logic                           rx_drop,
  output logic [31:0]                    rx_desc_addr
);
  import ede_pkg::*;

  typedef enum logic [3:0] {TX_IDLE, TX_RD0, TX_RD1, TX_RD2, TX_RD3,
                            TX_BUF1, TX_BUF2, TX_TS, TX_WRL, TX_WRH,
                            TX_WR0, TX_NEXT} ede_tx_state_t;
  typedef enum logic [2:0] {RX_OFF, RX_FETCH, RX_READY, RX_CLOSE,
                            RX_SUSP, RX_DROP} ede_rx_state_t;

  ede_tx_state_t tx_state;
  ede_rx_state_t rx_state;
  logic [31:0]   ctrl;
  logic [31:0]   tx_base;
  logic [31:0]   rx_base;
  logic          tx_poll;
  logic          rx_poll;
  logic          rbu;
  logic [15:0]   missed;
  logic          tx_start_q;
  logic [31:0]   tx_cur;
  logic [63:0]   ts_lat;
  logic [31:0]   rx_w0;
  logic          rx_reread;
  logic          mem_busy;
  logic          owner_rx;
  logic          tx_mem;
  logic          tx_we;
  logic [31:0]   tx_maddr;
  logic [31:0]   tx_mdata;
  logic          rx_mem;
  logic          tx_ack;
  logic          rx_ack;
  logic          fwd_ok;
  logic [31:0]   status_word;

  ede_desc_if d ();

  ede_tx_decode u_dec (
    .d (d.decoder)
  );

  ede_rx_gate u_gate (
    .store_fwd      (ctrl[C_STORE_FWD]),
    .threshold      (ctrl[C_THR_LSB +: THR_W]),
    .head_bytes     (rx_head_bytes),
    .head_complete  (rx_head_complete),
    .head_addr_pass (rx_head_addr_pass),
    .fwd_ok         (fwd_ok)
  );

  wire rx_start  = ctrl[C_RX_START];
  wire flush_dis = ctrl[C_FLUSH_DIS];
  wire tx_start  = ctrl[C_TX_START];
  wire wr_hit_rx_poll = reg_wr && reg_addr == REG_RX_POLL;
  wire wr_hit_tx_poll = reg_wr && reg_addr == REG_TX_POLL;

  // software registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl    <= CTRL_RST;
      tx_base <= BASE_RST;
      rx_base <= BASE_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:    ctrl    <= reg_wdata;
        REG_TX_BASE: tx_base <= reg_wdata;
        REG_RX_BASE: rx_base <= reg_wdata;
        default:     ;
      endcase
    end
  end

  // poll demands: a write landing on the clearing cycle is kept
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_poll    <= 1'b0;
      tx_poll    <= 1'b0;
      tx_start_q <= 1'b0;
    end
    else
    begin
      tx_start_q <= tx_start;
      if (wr_hit_rx_poll)
        rx_poll <= 1'b1;
      else if (rx_state == RX_FETCH)
        rx_poll <= 1'b0;
      if (wr_hit_tx_poll)
        tx_poll <= 1'b1;
      else if (tx_state == TX_RD0)
        tx_poll <= 1'b0;
    end
  end

  // buffer-unavailable flag, write one to clear, set wins
  wire rbu_set = rx_ack && !mem_rdata[B_OWN] &&
                 !(rx_reread && !flush_dis);
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rbu <= 1'b0;
    else if (rbu_set)
      rbu <= 1'b1;
    else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[S_RBU])
      rbu <= 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      missed <= 16'h0000;
    else if (rx_state == RX_DROP)
      missed <= missed + 16'h0001;
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[S_RBU]     = rbu;
    status_word[S_RX_SUSP] = rx_state == RX_SUSP;
    status_word[S_TX_BUSY] = tx_state != TX_IDLE;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:    reg_rdata <= ctrl;
        REG_TX_BASE: reg_rdata <= tx_base;
        REG_RX_BASE: reg_rdata <= rx_base;
        REG_STATUS:  reg_rdata <= status_word;
        REG_MISSED:  reg_rdata <= {16'h0000, missed};
        default:     reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // transmit memory request; word 1 is never a write target
  always_comb
  begin
    tx_mem   = 1'b1;
    tx_we    = 1'b0;
    tx_maddr = tx_cur;
    tx_mdata = d.w0 & ~(32'h0000_0001 << B_OWN);
    case (tx_state)
      TX_RD0: ;
      TX_RD1: tx_maddr = tx_cur + OFS_W1;
      TX_RD2: tx_maddr = tx_cur + OFS_W2;
      TX_RD3: tx_maddr = tx_cur + OFS_W3;
      TX_WRL:
      begin
        tx_we    = 1'b1;
        tx_maddr = tx_cur + OFS_W2;
        tx_mdata = ts_lat[31:0];
      end
      TX_WRH:
      begin
        tx_we    = 1'b1;
        tx_maddr = tx_cur + OFS_W3;
        tx_mdata = ts_lat[63:32];
      end
      TX_WR0: tx_we = 1'b1;
      default: tx_mem = 1'b0;
    endcase
  end

  assign rx_mem = rx_state == RX_FETCH || rx_state == RX_CLOSE;
  assign tx_ack = mem_busy && mem_ack && !owner_rx;
  assign rx_ack = mem_busy && mem_ack && owner_rx;
  assign mem_req = mem_busy;

  // one request at a time, turns alternate when both wait
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mem_busy  <= 1'b0;
      owner_rx  <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end
    else if (!mem_busy)
    begin
      if (tx_mem && (!rx_mem || owner_rx))
      begin
        mem_busy  <= 1'b1;
        owner_rx  <= 1'b0;
        mem_we    <= tx_we;
        mem_addr  <= tx_maddr;
        mem_wdata <= tx_mdata;
      end
      else if (rx_mem)
      begin
        mem_busy  <= 1'b1;
        owner_rx  <= 1'b1;
        mem_we    <= rx_state == RX_CLOSE;
        mem_addr  <= rx_cur_addr();
        mem_wdata <= rx_w0 & ~(32'h0000_0001 << B_OWN);
      end
    end
    else if (mem_ack)
      mem_busy <= 1'b0;
  end

  function automatic logic [31:0] rx_cur_addr();
    return rx_desc_addr;
  endfunction

  assign tx_buf_valid = tx_state == TX_BUF1 || tx_state == TX_BUF2;

  // transmit descriptor walk
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_state    <= TX_IDLE;
      tx_cur      <= BASE_RST;
      ts_lat      <= 64'h0000_0000_0000_0000;
      tx_buf_addr <= 32'h0000_0000;
      tx_buf_len  <= 13'h0000;
      d.w0        <= 32'h0000_0000;
      d.w1        <= 32'h0000_0000;
      d.w2        <= 32'h0000_0000;
      d.w3        <= 32'h0000_0000;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          if (tx_start && !tx_start_q)
            tx_cur <= tx_base;
          if (tx_start && (tx_poll || !tx_start_q))
            tx_state <= TX_RD0;
        end
        TX_RD0:
          if (tx_ack)
          begin
            d.w0 <= mem_rdata;
            // host-owned descriptor suspends until the next poll
            tx_state <= mem_rdata[B_OWN] ? TX_RD1 : TX_IDLE;
          end
        TX_RD1:
          if (tx_ack)
          begin
            d.w1     <= mem_rdata;
            tx_state <= TX_RD2;
          end
        TX_RD2:
          if (tx_ack)
          begin
            d.w2     <= mem_rdata;
            tx_state <= TX_RD3;
          end
        TX_RD3:
          if (tx_ack)
          begin
            d.w3 <= mem_rdata;
            if (d.use_buf1)
            begin
              tx_state    <= TX_BUF1;
              tx_buf_addr <= d.w2;
              tx_buf_len  <= d.size1;
            end
            else if (d.use_buf2)
            begin
              tx_state    <= TX_BUF2;
              tx_buf_addr <= mem_rdata;
              tx_buf_len  <= d.size2;
            end
            else
              tx_state <= d.ts_req ? TX_TS : TX_WR0;
          end
        TX_BUF1:
          if (tx_buf_ready)
          begin
            if (d.use_buf2)
            begin
              tx_state    <= TX_BUF2;
              tx_buf_addr <= d.w3;
              tx_buf_len  <= d.size2;
            end
            else
              tx_state <= d.ts_req ? TX_TS : TX_WR0;
          end
        TX_BUF2:
          if (tx_buf_ready)
            tx_state <= d.ts_req ? TX_TS : TX_WR0;
        TX_TS:
          if (tx_ts_valid)
          begin
            ts_lat   <= tx_ts;
            tx_state <= TX_WRL;
          end
        TX_WRL:
          if (tx_ack)
            tx_state <= TX_WRH;
        TX_WRH:
          if (tx_ack)
            tx_state <= TX_WR0;
        TX_WR0:
          if (tx_ack)
            tx_state <= TX_NEXT;
        TX_NEXT:
        begin
          // end of ring outranks chaining; pointer taken as given
          if (d.eor)
            tx_cur <= tx_base;
          else if (d.chain)
            tx_cur <= d.w3;
          else
            tx_cur <= tx_cur + DESC_STRIDE;
          tx_state <= tx_start ? TX_RD0 : TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  assign rx_xfer_en = fwd_ok && rx_state == RX_READY;
  assign rx_drop    = rx_state == RX_DROP;

  // receive descriptor fetch and suspend handling
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_state     <= RX_OFF;
      rx_desc_addr <= BASE_RST;
      rx_w0        <= 32'h0000_0000;
      rx_reread    <= 1'b0;
    end
    else
    begin
      case (rx_state)
        RX_OFF:
          if (rx_start)
          begin
            rx_state     <= RX_FETCH;
            rx_desc_addr <= rx_base;
            rx_reread    <= 1'b0;
          end
        RX_FETCH:
          if (rx_ack)
          begin
            rx_w0 <= mem_rdata;
            if (mem_rdata[B_OWN])
              rx_state <= RX_READY;
            else if (rx_reread && !flush_dis)
              rx_state <= RX_DROP;
            else
              rx_state <= RX_SUSP;
          end
        RX_READY:
          if (!rx_start)
            rx_state <= RX_OFF;
          else if (rx_buf_full || (rx_frame_end && rx_desc_closed))
            rx_state <= RX_CLOSE;
          else if (rx_frame_end || rx_poll)
            rx_state <= RX_FETCH;
        RX_CLOSE:
          if (rx_ack)
          begin
            // hand back and look one descriptor ahead
            rx_desc_addr <= rx_desc_addr + DESC_STRIDE;
            rx_reread    <= 1'b0;
            rx_state     <= RX_FETCH;
          end
        RX_SUSP:
          if (!rx_start)
            rx_state <= RX_OFF;
          else if (rx_new_frame)
          begin
            rx_reread <= 1'b1;
            rx_state  <= RX_FETCH;
          end
          else if (rx_poll)
          begin
            rx_reread <= 1'b0;
            rx_state  <= RX_FETCH;
          end
        RX_DROP:
          // the dropped frame still counts in this cycle
          rx_state <= (rx_fifo_frames > 8'h01) ? RX_FETCH : RX_SUSP;
        default: rx_state <= RX_OFF;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_skip_buf1;
    tx_state == TX_RD3 && tx_ack && d.size1 == 13'h0000
      |=> tx_state != TX_BUF1;
  endproperty
  a_skip_buf1: assert property (p_skip_buf1)
    else $error("empty buffer one was offered");

  property p_chain_no_buf2;
    tx_state == TX_BUF2 |-> !d.chain && tx_buf_len == d.size2;
  endproperty
  a_chain_no_buf2: assert property (p_chain_no_buf2)
    else $error("second buffer used while chained");

  property p_ts_low;
    tx_state == TX_WRL && mem_busy && !owner_rx
      |-> mem_we && mem_wdata == ts_lat[31:0] && mem_addr == tx_cur + OFS_W2;
  endproperty
  a_ts_low: assert property (p_ts_low)
    else $error("timestamp low written wrongly");

  property p_ts_high;
    tx_state == TX_WRH && mem_busy && !owner_rx
      |-> mem_we && mem_wdata == ts_lat[63:32] &&
          mem_addr == tx_cur + OFS_W3;
  endproperty
  a_ts_high: assert property (p_ts_high)
    else $error("timestamp high written wrongly");

  property p_own_release;
    tx_state == TX_WR0 && mem_busy && !owner_rx
      |-> mem_we && !mem_wdata[B_OWN] && mem_addr == tx_cur;
  endproperty
  a_own_release: assert property (p_own_release)
    else $error("ownership not released");

  property p_chain_follow;
    tx_state == TX_NEXT && d.chain && !d.eor |=> tx_cur == $past(d.w3);
  endproperty
  a_chain_follow: assert property (p_chain_follow)
    else $error("chained pointer not followed");

  property p_forward;
    rx_xfer_en |-> rx_state == RX_READY &&
      (ctrl[C_STORE_FWD] ? rx_head_complete
       : rx_head_addr_pass && rx_head_bytes >= ctrl[C_THR_LSB +: THR_W]);
  endproperty
  a_forward: assert property (p_forward)
    else $error("frame forwarded too early");

  property p_drop_count;
    rx_state == RX_DROP |=> missed == $past(missed) + 16'h0001;
  endproperty
  a_drop_count: assert property (p_drop_count)
    else $error("missed counter not advanced");

  property p_keep_frame;
    rx_state == RX_FETCH && rx_ack && !mem_rdata[B_OWN] && rx_reread &&
      flush_dis |=> rx_state == RX_SUSP && rbu && !rx_drop;
  endproperty
  a_keep_frame: assert property (p_keep_frame)
    else $error("flush disabled frame not kept");

  property p_start_fetch;
    rx_state == RX_OFF && rx_start |=> rx_state == RX_FETCH;
  endproperty
  a_start_fetch: assert property (p_start_fetch)
    else $error("no fetch after receive start");

  c_ts_wb: cover property (tx_state == TX_WRH && tx_ack);
  c_chain: cover property (tx_state == TX_NEXT && d.chain);
  c_drop: cover property (rx_state == RX_DROP);
  c_resume: cover property (rx_reread && rx_state == RX_READY);
endmodule
`default_nettype wire

// ===== verilog/ede_pkg.sv
// shared constants for the ethernet descriptor dma engine
// assumes 32-bit host memory words and 16-byte descriptors
package ede_pkg;
  // register port
  localparam int REG_AW = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_RX_POLL = 8'h04;
  localparam logic [7:0] REG_TX_POLL = 8'h08;
  localparam logic [7:0] REG_TX_BASE = 8'h0C;
  localparam logic [7:0] REG_RX_BASE = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_MISSED  = 8'h18;
  // control bits in dma_operation_mode_reg
  localparam int C_RX_START  = 0;
  localparam int C_FLUSH_DIS = 1;
  localparam int C_STORE_FWD = 2;
  localparam int C_TX_START  = 3;
  localparam int C_THR_LSB   = 8;
  localparam int THR_W       = 12;
  // status bits
  localparam int S_RBU     = 0;
  localparam int S_RX_SUSP = 1;
  localparam int S_TX_BUSY = 2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_4000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  // descriptor word offsets and stride
  localparam logic [31:0] OFS_W1      = 32'h0000_0004;
  localparam logic [31:0] OFS_W2      = 32'h0000_0008;
  localparam logic [31:0] OFS_W3      = 32'h0000_000C;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  // descriptor field positions
  localparam int B_OWN   = 31;
  localparam int B_LS    = 29;
  localparam int B_TSEN  = 25;
  localparam int B_EOR   = 21;
  localparam int B_CHAIN = 20;
  localparam int B_SIZE1 = 0;
  localparam int B_SIZE2 = 16;
  localparam int SIZE_W  = 13;

  function automatic logic [SIZE_W-1:0] size_field(input logic [31:0] w,
                                                   input int lsb);
    return w[lsb +: SIZE_W];
  endfunction
endpackage

// ===== verilog/ede_desc_if.sv
// transmit descriptor words and their decoded fields
// assumes one holder writes the words and one decoder reads them
`timescale 1ns/1ps
`default_nettype none
interface ede_desc_if;
  logic [31:0] w0;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic        own;
  logic        chain;
  logic        eor;
  logic        last;
  logic        ts_req;
  logic [12:0] size1;
  logic [12:0] size2;
  logic        use_buf1;
  logic        use_buf2;
  modport holder (output w0, w1, w2, w3,
                  input own, chain, eor, last, ts_req, size1, size2,
                  input use_buf1, use_buf2);
  modport decoder (input w0, w1,
                   output own, chain, eor, last, ts_req, size1, size2,
                   output use_buf1, use_buf2);
endinterface
`default_nettype wire

// ===== verilog/ede_tx_decode.sv
// decodes transmit descriptor words 0 and 1
// assumes the words are held stable by the transmit state machine
`timescale 1ns/1ps
`default_nettype none
module ede_tx_decode (
  // descriptor words in, fields out
  ede_desc_if.decoder d
);
  import ede_pkg::*;

  assign d.own    = d.w0[B_OWN];
  assign d.chain  = d.w0[B_CHAIN];
  assign d.eor    = d.w0[B_EOR];
  assign d.last   = d.w0[B_LS];
  assign d.ts_req = d.w0[B_LS] & d.w0[B_TSEN];
  // reserved bits of word 1 are never looked at
  assign d.size1  = size_field(d.w1, B_SIZE1);
  assign d.size2  = size_field(d.w1, B_SIZE2);
  assign d.use_buf1 = d.size1 != 13'h0000;
  // a chained descriptor has no second buffer
  assign d.use_buf2 = !d.w0[B_CHAIN] && d.size2 != 13'h0000;
endmodule
`default_nettype wire

// ===== verilog/ede_rx_gate.sv
// decides when the head frame of the receive fifo may go to memory
// assumes fifo status inputs are synchronous to the engine clock
`timescale 1ns/1ps
`default_nettype none
module ede_rx_gate (
  // mode
  input  wire logic                     store_fwd,
  input  wire logic [ede_pkg::THR_W-1:0] threshold,
  // receive fifo head frame
  input  wire logic [ede_pkg::THR_W-1:0] head_bytes,
  input  wire logic                     head_complete,
  input  wire logic                     head_addr_pass,
  // decision
  output logic                          fwd_ok
);
  import ede_pkg::*;

  // cut-through needs both the byte threshold and a filter pass
  assign fwd_ok = store_fwd ? head_complete
                            : (head_bytes >= threshold) && head_addr_pass;
endmodule
`default_nettype wire

// ===== tb/ede_far_model.sv
// far-side model: host memory and mac transmit side
// assumes the engine holds each memory request until mem_ack
`timescale 1ns/1ps
`default_nettype none
module ede_far_model (
  // clock
  input  wire logic        clk,
  // host memory
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // mac transmit side
  input  wire logic        tx_buf_valid,
  input  wire logic [31:0] tx_buf_addr,
  input  wire logic [12:0] tx_buf_len,
  output logic             tx_buf_ready,
  output logic             tx_ts_valid,
  output logic [63:0]      tx_ts
);
  logic [31:0] mem [0:31];
  logic [31:0] last_desc = '0;
  logic [31:0] buf_addr = '0;
  logic [12:0] buf_len = '0;
  // second offered buffer: address above, length below
  logic [44:0] offer2 = '0;
  int          wait_n = 0, slow = 0, offers = 0, reads = 0;
  assign tx_ts = 64'h0BAD_F00D_1357_2468;
  initial
  begin
    {mem_ack, tx_buf_ready, tx_ts_valid, mem_rdata} = '0;
    foreach (mem[i]) mem[i] = '0;
  end
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    // idle bus inverts each cycle, so it does not hold the last word
    mem_rdata <= ~mem_rdata;
    wait_n <= mem_req ? wait_n + 1 : 0;
    if (mem_req && !mem_ack && wait_n >= slow)
    begin
      mem_ack <= 1'b1;
      wait_n <= 0;
      if (mem_we)
        mem[mem_addr[6:2]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[6:2]];
      if (!mem_we && mem_addr[3:0] == 4'h0)
      begin
        last_desc <= mem_addr;
        reads <= reads + 1;
      end
    end
    tx_buf_ready <= tx_buf_valid && !tx_buf_ready;
    tx_ts_valid <= tx_buf_valid && tx_buf_ready;
    if (tx_buf_valid && tx_buf_ready && offers == 0)
    begin
      buf_addr <= tx_buf_addr;
      buf_len <= tx_buf_len;
    end
    if (tx_buf_valid && tx_buf_ready && offers == 1)
      offer2 <= {tx_buf_addr, tx_buf_len};
    if (tx_buf_valid && tx_buf_ready)
      offers <= offers + 1;
  end
endmodule
`default_nettype wire

// ===== tb/test_eth_dma_descriptor_engine.sv
// self-checking bench for the descriptor dma engine
// assumes the far-side model owns memory and the mac transmit side
`timescale 1ns/1ps
`default_nettype none
module test_eth_dma_descriptor_engine;
  import ede_pkg::*;
  logic        clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = '0, rx_fifo_frames = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] tx_buf_addr, rx_desc_addr;
  logic        mem_req, mem_we, mem_ack, tx_buf_valid, tx_buf_ready;
  logic        tx_ts_valid, rx_xfer_en, rx_drop;
  logic [12:0] tx_buf_len;
  logic [63:0] tx_ts;
  logic        rx_new_frame = 0, rx_buf_full = 0, rx_frame_end = 0;
  logic        rx_desc_closed = 0, rx_head_complete = 0;
  logic        rx_head_addr_pass = 0;
  logic [11:0] rx_head_bytes = '0;
  int          mismatches = 0, comparisons = 0, cycles = 0, drops = 0, r0;
  ede_dma_engine u_ede_dma_engine (.clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .tx_buf_valid, .tx_buf_addr, .tx_buf_len,
    .tx_buf_ready, .tx_ts_valid, .tx_ts, .rx_new_frame, .rx_head_bytes,
    .rx_head_complete, .rx_head_addr_pass, .rx_fifo_frames, .rx_buf_full,
    .rx_frame_end, .rx_desc_closed, .rx_xfer_en, .rx_drop, .rx_desc_addr);
  ede_far_model u_ede_far_model (.clk, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .tx_buf_valid, .tx_buf_addr,
    .tx_buf_len, .tx_buf_ready, .tx_ts_valid, .tx_ts);
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (rx_drop)
    begin
      drops++;
      rx_fifo_frames <= rx_fifo_frames - 8'h01;
    end
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic check(input string n, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(n, reg_rdata, e);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    {rx_new_frame, rx_buf_full, rx_frame_end} <= m;
    @(posedge clk);
    {rx_new_frame, rx_buf_full, rx_frame_end} <= 3'h0;
    repeat (40) @(posedge clk);
  endtask
  task automatic s_tx();
    u_ede_far_model.mem[0] = 32'hA210_0000;
    // reserved bits set around both size fields
    u_ede_far_model.mem[1] = 32'hE005_E007;
    u_ede_far_model.mem[2] = 32'h0000_0103;
    u_ede_far_model.mem[3] = 32'h0000_0020;
    u_ede_far_model.mem[8] = 32'h8010_0000;
    u_ede_far_model.mem[9] = 32'h0009_0000;
    u_ede_far_model.mem[11] = 32'h0000_0030;
    // ring mode, end of ring, only a second buffer
    u_ede_far_model.mem[12] = 32'h8020_0000;
    u_ede_far_model.mem[13] = 32'h0005_0000;
    u_ede_far_model.mem[15] = 32'h0000_0201;
    wr(REG_TX_BASE, 32'h0);
    wr(REG_CTRL, CTRL_RST | 32'h8);
    for (int i = 0; i < 500 && u_ede_far_model.last_desc !== 32'h30; i++)
      @(posedge clk);
    check("chain", u_ede_far_model.last_desc, 32'h30);
    for (int j = 0; j < 500 && u_ede_far_model.mem[12][31] !== 1'b0; j++)
      @(posedge clk);
    repeat (12) @(posedge clk);
    check("offers", u_ede_far_model.offers, 2);
    check("wrap", u_ede_far_model.last_desc, 32'h0);
    check("buf2 addr", u_ede_far_model.offer2[44:13], 32'h201);
    check("buf2 len", u_ede_far_model.offer2[12:0], 5);
    check("buf addr", u_ede_far_model.buf_addr, 32'h103);
    check("buf len", u_ede_far_model.buf_len, 7);
    check("ts low", u_ede_far_model.mem[2], 32'h1357_2468);
    check("ts high", u_ede_far_model.mem[3], 32'h0BAD_F00D);
    check("own a", u_ede_far_model.mem[0][31], 0);
    check("own b", u_ede_far_model.mem[8][31], 0);
    check("word1", u_ede_far_model.mem[1], 32'hE005_E007);
    r0 = u_ede_far_model.reads;
    u_ede_far_model.mem[0] = 32'h8020_0000;
    wr(REG_TX_POLL, 32'h0);
    repeat (60) @(posedge clk);
    check("tx poll", u_ede_far_model.reads - r0, 2);
    check("both bufs", u_ede_far_model.offers, 4);
    check("own c", u_ede_far_model.mem[0][31], 0);
  endtask
  task automatic s_rx();
    u_ede_far_model.slow = 2;
    wr(REG_RX_BASE, 32'h40);
    wr(REG_CTRL, CTRL_RST | 32'h1);
    repeat (40) @(posedge clk);
    check("rx fetch", u_ede_far_model.last_desc, 32'h40);
    wr(REG_STATUS, 32'h1);
    rx_fifo_frames <= 8'h02;
    r0 = u_ede_far_model.reads;
    pulse(3'h4);
    check("drops", drops, 2);
    check("rereads", u_ede_far_model.reads - r0, 2);
    rdc("missed", REG_MISSED, 32'h2);
    rdc("status", REG_STATUS, 32'h2);
    rx_fifo_frames <= 8'h01;
    wr(REG_CTRL, CTRL_RST | 32'h3);
    pulse(3'h4);
    check("kept", drops, 2);
    rdc("unavail", REG_STATUS, 32'h3);
    rdc("missed", REG_MISSED, 32'h2);
    u_ede_far_model.mem[16] = 32'h8000_0000;
    rx_head_bytes <= 12'h040;
    rx_head_addr_pass <= 1'b1;
    pulse(3'h4);
    check("resume", rx_xfer_en, 1);
    rx_head_bytes <= 12'h03F;
    @(posedge clk);
    #1 check("below thr", rx_xfer_en, 0);
    wr(REG_CTRL, CTRL_RST | 32'h7);
    rx_head_complete <= 1'b1;
    @(posedge clk);
    #1 check("whole", rx_xfer_en, 1);
    r0 = u_ede_far_model.reads;
    u_ede_far_model.mem[20] = 32'h8000_0000;
    pulse(3'h2);
    check("rx own", u_ede_far_model.mem[16], 32'h0);
    pulse(3'h1);
    check("refetch", u_ede_far_model.reads - r0, 2);
    check("ahead", rx_desc_addr, 32'h50);
    rx_desc_closed <= 1'b1;
    pulse(3'h1);
    check("closed", rx_desc_addr, 32'h60);
    r0 = u_ede_far_model.reads;
    wr(REG_RX_POLL, 32'h0);
    repeat (20) @(posedge clk);
    check("poll", u_ede_far_model.reads - r0, 1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdc("ctrl", REG_CTRL, CTRL_RST);
    rdc("unmapped", 8'h1C, 32'h0);
    s_tx();
    s_rx();
    wrap_up();
  end
endmodule
`default_nettype wire
